//--- line_sensor_map.svh
// Purpose: shared constants of the line sensor readout link
// Assumes: 100 MHz system clock on both ends
// Notes: definitions only
`ifndef LINE_SENSOR_MAP_SVH
`define LINE_SENSOR_MAP_SVH
// ==================================================
// system clock and sensor clock
`define SYS_CLK_HZ 100000000
`define SENSOR_CLK_HZ 5000000
`define SENSOR_CLK_MIN_HZ 200000
`define SENSOR_CLK_MAX_HZ 10000000
`define SENSOR_HALF_CYC (`SYS_CLK_HZ / (2 * `SENSOR_CLK_HZ))
`define SENSOR_MIN_PERIOD_CYC (`SYS_CLK_HZ / `SENSOR_CLK_MAX_HZ)
`define DUTY_MIN_PCT 45
`define DUTY_MAX_PCT 55
// ==================================================
// line-begin pulse limits, in sensor clock periods
`define BEGIN_PERIOD_MIN 16'h0046
`define BEGIN_HIGH_MIN 16'h0006
`define BEGIN_LOW_MIN 16'h0040
// ==================================================
// readout sequence, in strobes; integration extra in sensor clocks
`define PIXELS_PER_LINE 12'h9c0
`define FIRST_VALID_STROBE 12'h033
`define LAST_DARK_STROBE 12'h032
`define LAST_STROBE 12'h9f2
`define INTEG_EXTRA_CYC 16'h0022
`endif

//--- line_sensor_pkg.sv
// Purpose: types of the line sensor readout link
// Assumes: nothing
// Notes: constants live in line_sensor_map.svh
`default_nettype none
package line_sensor_pkg;
  // ==================================================
  // device end
  typedef enum logic [2:0] {dev_idle, dev_integ, dev_wait, dev_shift, dev_done} dev_state_e;
  typedef struct packed {
    dev_state_e state;
    logic sclk_q;
    logic lbp_q;
    logic [15:0] high_cnt;
    logic [15:0] integ;
    logic integ_valid;
    logic [11:0] strobe_cnt;
    logic strobe;
    logic [11:0] video;
    logic [11:0] pix_index;
    logic scan_done;
    logic [7:0] rate_cnt;
    logic rate_seen;
    logic rate_fault;
    logic busy;
  } dev_s;
  // ==================================================
  // controller end
  typedef enum logic [1:0] {ctl_idle, ctl_armed, ctl_high, ctl_low} ctl_state_e;
  typedef struct packed {
    ctl_state_e state;
    logic [7:0] div_cnt;
    logic sclk;
    logic lbp;
    logic [15:0] target;
    logic [15:0] per_cnt;
    logic strobe_q;
    logic done_q;
    logic [11:0] strobe_cnt;
    logic [11:0] sample;
    logic sample_valid;
    logic [11:0] sample_index;
    logic line_done;
    logic count_ok;
    logic scan_seen;
    logic busy;
  } ctl_s;
endpackage
`default_nettype wire

//--- line_sensor_if.sv
// Purpose: pins between sensor and its timing controller
// Assumes: one system clock on both ends
// Notes: video stands for the digitised analog sample
`default_nettype none
interface line_sensor_if;
  logic sensor_clk;
  logic line_begin_pulse;
  logic [11:0] video;
  logic pixel_strobe;
  logic scan_done_flag;
  modport sensor (
    input sensor_clk,
    input line_begin_pulse,
    output video,
    output pixel_strobe,
    output scan_done_flag
  );
  modport controller (
    output sensor_clk,
    output line_begin_pulse,
    input video,
    input pixel_strobe,
    input scan_done_flag
  );
endinterface
`default_nettype wire

//--- line_sensor_controller.sv
// Purpose: timing controller and video capture for the line sensor
// Assumes: sensor end on the same system clock
// Notes: a line ends only when scan done is seen
`default_nettype none
`include "line_sensor_map.svh"
module line_sensor_controller
  import line_sensor_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // link
  line_sensor_if.controller link,
  // line request
  input wire logic start_in,
  input wire logic [15:0] high_periods_in,
  output logic busy_out,
  // captured video
  output logic [11:0] sample_out,
  output logic sample_valid_out,
  output logic [11:0] sample_index_out,
  output logic line_done_out,
  output logic count_ok_out
);
  ctl_s st;
  ctl_s next_st;
  logic sclk_fall;
  logic strobe_rise;
  logic done_rise;
  logic [11:0] strobe_next;

  // ==================================================
  // sensor clock: even divider keeps duty at 50 %
  assign sclk_fall = (st.div_cnt == 8'(`SENSOR_HALF_CYC - 1)) && st.sclk;
  assign strobe_rise = link.pixel_strobe && !st.strobe_q;
  assign done_rise = link.scan_done_flag && !st.done_q;
  assign strobe_next = st.strobe_cnt + 12'h001;

  always_comb begin
    next_st = st;
    next_st.strobe_q = link.pixel_strobe;
    next_st.done_q = link.scan_done_flag;
    next_st.sample_valid = 1'b0;
    next_st.line_done = 1'b0;
    if (st.div_cnt == 8'(`SENSOR_HALF_CYC - 1)) begin
      next_st.div_cnt = 8'h00;
      next_st.sclk = !st.sclk;
    end else begin
      next_st.div_cnt = st.div_cnt + 8'h01;
    end
    // line-begin pulse moves only on falling sensor clock edges
    unique case (st.state)
      ctl_idle: begin
        if (start_in) begin
          // exposure set by the high share of the period
          next_st.target = (high_periods_in < `BEGIN_HIGH_MIN) ? `BEGIN_HIGH_MIN
                                                              : high_periods_in;
          next_st.state = ctl_armed;
          next_st.busy = 1'b1;
        end
      end
      ctl_armed: begin
        if (sclk_fall) begin
          next_st.lbp = 1'b1;
          next_st.per_cnt = 16'h0000;
          next_st.scan_seen = 1'b0;
          next_st.strobe_cnt = 12'h000;
          next_st.state = ctl_high;
        end
      end
      ctl_high: begin
        if (sclk_fall) begin
          next_st.per_cnt = st.per_cnt + 16'h0001;
          if (st.per_cnt + 16'h0001 == st.target) begin
            next_st.lbp = 1'b0;
            next_st.per_cnt = 16'h0000;
            next_st.state = ctl_low;
          end
        end
      end
      ctl_low: begin
        // low of 64 on top of high of 6 also covers the period of 70
        if (sclk_fall && st.per_cnt < `BEGIN_LOW_MIN) begin
          next_st.per_cnt = st.per_cnt + 16'h0001;
        end
        if (st.per_cnt >= `BEGIN_LOW_MIN && st.scan_seen) begin
          next_st.state = ctl_idle;
          next_st.busy = 1'b0;
        end
      end
    endcase
    // capture on the strobe's rising edge, from the 51st on
    if (strobe_rise) begin
      next_st.strobe_cnt = strobe_next;
      if (strobe_next >= `FIRST_VALID_STROBE && strobe_next <= `LAST_STROBE) begin
        next_st.sample = link.video;
        next_st.sample_valid = 1'b1;
        next_st.sample_index = strobe_next - `FIRST_VALID_STROBE;
      end
    end
    if (done_rise) begin
      next_st.line_done = 1'b1;
      next_st.count_ok = (st.strobe_cnt == `LAST_STROBE);
      next_st.scan_seen = 1'b1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      st <= '{state: ctl_idle, target: `BEGIN_HIGH_MIN, default: '0};
    end else begin
      st <= next_st;
    end
  end

  // ==================================================
  // outputs
  assign link.sensor_clk = st.sclk;
  assign link.line_begin_pulse = st.lbp;
  assign busy_out = st.busy;
  assign sample_out = st.sample;
  assign sample_valid_out = st.sample_valid;
  assign sample_index_out = st.sample_index;
  assign line_done_out = st.line_done;
  assign count_ok_out = st.count_ok;
endmodule // line_sensor_controller
`default_nettype wire

//--- line_sensor_device.sv
// Purpose: readout timing of a linear image sensor with its own timing generator
// Assumes: sensor clock and line-begin pulse are synchronous to clk_in
// Notes: the analog video is stood in for by a 12-bit sample from the user side
`default_nettype none
`include "line_sensor_map.svh"
// Overview of operation
// - controller keeps begin pulse period, high, low minimums
// - controller keeps sensor clock duty 45 to 55 percent
// - shifting starts first clock rise after pulse falls
// - exposure set by high share of begin pulse
// - integration equals high time plus 34 clocks
// - first valid video at strobe number 51
// - one pixel per sensor clock, 10 MHz maximum
// - video valid on strobe rising edge
// - each line delivers 2496 pixel samples
// - controller runs clock 200 kHz to 10 MHz
module line_sensor_device
  import line_sensor_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // link
  line_sensor_if.sensor link,
  // pixel source
  output logic [11:0] pixel_index_out,
  input wire logic [11:0] pixel_data_in,
  // status
  output logic [15:0] integ_cycles_out,
  output logic integ_valid_out,
  output logic busy_out,
  output logic rate_fault_out
);
  dev_s st;
  dev_s next_st;
  logic sclk_rise;
  logic sclk_fall;
  logic lbp_rise;
  logic lbp_fall;
  logic [11:0] strobe_next;

  // ==================================================
  // helpers
  // the link pins are plain levels, so an edge is a level against its copy
  function automatic logic went_high(input logic level, input logic last_level);
    return level && !last_level;
  endfunction

  function automatic logic went_low(input logic level, input logic last_level);
    return !level && last_level;
  endfunction

  // counters saturate so a stalled clock reads as slow, never as fast
  function automatic logic [7:0] sat_inc8(input logic [7:0] value);
    if (value == 8'hff) begin
      return value;
    end
    return value + 8'h01;
  endfunction

  function automatic logic [15:0] sat_inc16(input logic [15:0] value);
    if (value == 16'hffff) begin
      return value;
    end
    return value + 16'h0001;
  endfunction

  // a very long high time would wrap the sum; the report clips instead
  function automatic logic [15:0] integ_total(input logic [15:0] high);
    logic [16:0] sum;
    sum = {1'b0, high} + {1'b0, `INTEG_EXTRA_CYC};
    if (sum[16]) begin
      return 16'hffff;
    end
    return sum[15:0];
  endfunction

  // strobes whose rise asks the source for a pixel after the dark ones
  function automatic logic wants_pixel(input logic [11:0] count);
    return (count >= `LAST_DARK_STROBE) && (count < `LAST_STROBE);
  endfunction

  // position along the line of the pixel that a strobe count asks for
  function automatic logic [11:0] pixel_of(input logic [11:0] count);
    return count - `LAST_DARK_STROBE;
  endfunction

  // ==================================================
  // edge detection on the synchronous link inputs
  assign sclk_rise = went_high(link.sensor_clk, st.sclk_q);
  assign sclk_fall = went_low(link.sensor_clk, st.sclk_q);
  assign lbp_rise = went_high(link.line_begin_pulse, st.lbp_q);
  assign lbp_fall = went_low(link.line_begin_pulse, st.lbp_q);
  assign strobe_next = st.strobe_cnt + 12'h001;

  // ==================================================
  // timing generator
  always_comb begin
    next_st = st;
    next_st.sclk_q = link.sensor_clk;
    next_st.lbp_q = link.line_begin_pulse;
    next_st.integ_valid = 1'b0;

    // clock rate watch: rises closer than 10 cycles mean above 10 MHz
    if (sclk_rise) begin
      if (st.rate_seen && st.rate_cnt < 8'(`SENSOR_MIN_PERIOD_CYC)) begin
        next_st.rate_fault = 1'b1;
      end
      next_st.rate_cnt = 8'h01;
      next_st.rate_seen = 1'b1;
    end else begin
      next_st.rate_cnt = sat_inc8(st.rate_cnt);
    end

    if (lbp_rise) begin
      // a new line aborts any scan still running
      // limitation: the aborted line never gets its scan done pulse
      next_st.state = dev_integ;
      next_st.high_cnt = 16'h0000;
      next_st.strobe = 1'b0;
      next_st.strobe_cnt = 12'h000;
      next_st.scan_done = 1'b0;
      next_st.video = 12'h000;
      next_st.rate_fault = 1'b0;
    end else begin
      unique case (st.state)
        dev_idle: begin
          // waits for a begin pulse; lone falls are ignored
        end
        dev_integ: begin
          // high time measured in sensor clocks
          if (sclk_rise) begin
            next_st.high_cnt = sat_inc16(st.high_cnt);
          end
          if (lbp_fall) begin
            next_st.integ = integ_total(st.high_cnt);
            next_st.integ_valid = 1'b1;
            next_st.state = dev_wait;
          end
        end
        dev_wait: begin
          // shift register starts on the next clock rise
          if (sclk_rise) begin
            next_st.state = dev_shift;
            next_st.strobe_cnt = 12'h001;
            next_st.strobe = 1'b1;
          end
        end
        dev_shift: begin
          // one strobe and one pixel per sensor clock
          if (sclk_rise) begin
            next_st.strobe_cnt = strobe_next;
            next_st.strobe = 1'b1;
            if (wants_pixel(strobe_next)) begin
              // index asked half a clock ahead so the source has time to answer
              next_st.pix_index = pixel_of(strobe_next);
            end
          end
          if (sclk_fall) begin
            next_st.strobe = 1'b0;
            if (st.strobe_cnt == `LAST_STROBE) begin
              next_st.scan_done = 1'b1;
              next_st.video = 12'h000;
              next_st.state = dev_done;
            end else if (st.strobe_cnt >= `LAST_DARK_STROBE) begin
              // video settles on the fall, half a clock before the strobe rises
              next_st.video = pixel_data_in;
            end
          end
        end
        dev_done: begin
          // done flag stands one sensor clock period
          if (sclk_fall) begin
            next_st.scan_done = 1'b0;
            next_st.state = dev_idle;
          end
        end
        default: begin
          // an upset code falls back to waiting for a begin pulse
          next_st.state = dev_idle;
        end
      endcase
    end
    // registered so the busy pin comes straight off a flop
    next_st.busy = (next_st.state != dev_idle);
  end

  // ==================================================
  // state register
  // synchronous reset; every field starts at zero so all pins start low
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      st <= '{state: dev_idle, default: '0};
    end else begin
      st <= next_st;
    end
  end

  // ==================================================
  // outputs
  assign link.video = st.video;
  assign link.pixel_strobe = st.strobe;
  assign link.scan_done_flag = st.scan_done;
  assign pixel_index_out = st.pix_index;
  assign integ_cycles_out = st.integ;
  assign integ_valid_out = st.integ_valid;
  assign busy_out = st.busy;
  assign rate_fault_out = st.rate_fault;
endmodule // line_sensor_device
`default_nettype wire

//--- line_sensor_checker.sv
// Purpose: wire checks between the sensor end and the controller end
// Assumes: both ends on clk_in, sensor clock made by the controller
// Notes: strobes are counted from the fall of the begin pulse
`default_nettype none
`include "line_sensor_map.svh"
module line_sensor_checker (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // link
  input wire logic sensor_clk,
  input wire logic line_begin_pulse,
  input wire logic [11:0] video,
  input wire logic pixel_strobe,
  input wire logic scan_done_flag
);
  localparam int PER = 2 * `SENSOR_HALF_CYC;
  localparam int MIN_PER = `SENSOR_MIN_PERIOD_CYC;
  localparam int MAX_PER = `SYS_CLK_HZ / `SENSOR_CLK_MIN_HZ;
  logic prev_strobe, prev_clk, ran, clk_seen;
  logic [9:0] span;
  logic [11:0] cnt;
  logic [15:0] gap, hi, lo;
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // ==================================================
  // helper counters
  always_ff @(posedge clk_in) begin
    prev_strobe <= pixel_strobe;
    prev_clk <= sensor_clk;
    ran <= !rst_in && (ran || line_begin_pulse);
    cnt <= (rst_in || line_begin_pulse) ? 12'h000 : cnt + 12'(pixel_strobe & ~prev_strobe);
    gap <= (pixel_strobe && !prev_strobe) ? 16'h0000 : gap + 16'h0001;
    hi <= line_begin_pulse ? hi + 16'(sensor_clk & ~prev_clk) : 16'h0000;
    lo <= line_begin_pulse ? 16'h0000 : lo + 16'(sensor_clk & ~prev_clk);
    clk_seen <= !rst_in && (clk_seen || (sensor_clk && !prev_clk));
    span <= (sensor_clk && !prev_clk) ? 10'h001 : span + 10'(span != 10'h3ff);
  end
  // ==================================================
  // assertions
  a_clock_duty_span: assert property ($rose(sensor_clk) |=> sensor_clk[*8] ##[1:3] !sensor_clk)
    else $error("sensor clock high time out of range");
  a_pulse_high_min: assert property ($fell(line_begin_pulse) |-> hi >= `BEGIN_HIGH_MIN)
    else $error("begin pulse high too short");
  a_pulse_low_min: assert property ($rose(line_begin_pulse) && ran |-> lo >= `BEGIN_LOW_MIN)
    else $error("begin pulse low too short");
  a_clock_rate_span: assert property (
    $rose(sensor_clk) && clk_seen |-> span >= MIN_PER && span <= MAX_PER)
    else $error("sensor clock rate out of range");
  a_quiet_during_pulse: assert property (
    line_begin_pulse && $past(line_begin_pulse, 3) |-> !pixel_strobe)
    else $error("strobe while begin pulse high");
  a_first_strobe_soon: assert property (
    $fell(line_begin_pulse) |-> !pixel_strobe[*8] ##[1:8] $rose(pixel_strobe))
    else $error("first strobe not on next clock rise");
  a_strobe_in_high: assert property (
    pixel_strobe && !sensor_clk |-> $past(sensor_clk, 3))
    else $error("strobe outlives sensor clock high");
  a_video_held_strobe: assert property ($rose(pixel_strobe) |=> $stable(video)[*4])
    else $error("video moved under strobe");
  a_strobe_one_clk: assert property ($rose(pixel_strobe) && cnt != 12'h000 |-> gap == PER - 1)
    else $error("strobe spacing not one sensor clock");
  a_strobe_count_cap: assert property ($rose(pixel_strobe) |-> cnt < `LAST_STROBE)
    else $error("too many strobes in a line");
  a_done_after_last: assert property ($rose(scan_done_flag) |-> cnt == `LAST_STROBE)
    else $error("scan done at wrong strobe count");
  a_done_one_period: assert property (
    $rose(scan_done_flag) |=> scan_done_flag[*8] ##[9:13] !scan_done_flag)
    else $error("scan done width wrong");
  cover property ($rose(scan_done_flag));
  cover property ($fell(line_begin_pulse) && hi == `BEGIN_HIGH_MIN);
  cover property ($rose(pixel_strobe) && cnt == `LAST_DARK_STROBE);
endmodule // line_sensor_checker
`default_nettype wire

//--- linear_sensor_readout_timing_tb.sv
// Purpose: self-checking bench, controller end facing sensor end
// Assumes: 100 MHz clk_in, 5 MHz sensor clock
// Notes: a line is about 51k cycles, so only two lines are run
`default_nettype none
`include "line_sensor_map.svh"
module linear_sensor_readout_timing_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [11:0] PAT = 12'h5a5;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic start_in = 1'b0;
  logic [15:0] high_periods_in = 16'h0000;
  logic [11:0] pixel_data_in = 12'h000;
  logic [11:0] pixel_index, sample, sample_index, wk;
  logic [15:0] integ;
  logic integ_valid, dev_busy, rate_fault, busy, sample_valid, line_done, count_ok, prev_strobe;
  int failures = 0;
  int compares = 0;
  line_sensor_if link ();
  line_sensor_device line_sensor_device_inst (.clk_in(clk_in), .rst_in(rst_in),
    .link(link.sensor), .pixel_index_out(pixel_index), .pixel_data_in(pixel_data_in),
    .integ_cycles_out(integ), .integ_valid_out(integ_valid), .busy_out(dev_busy),
    .rate_fault_out(rate_fault));
  line_sensor_controller line_sensor_controller_inst (.clk_in(clk_in), .rst_in(rst_in),
    .link(link.controller), .start_in(start_in), .high_periods_in(high_periods_in),
    .busy_out(busy), .sample_out(sample), .sample_valid_out(sample_valid),
    .sample_index_out(sample_index), .line_done_out(line_done), .count_ok_out(count_ok));
  line_sensor_checker line_sensor_checker_inst (.clk_in(clk_in), .rst_in(rst_in),
    .sensor_clk(link.sensor_clk), .line_begin_pulse(link.line_begin_pulse),
    .video(link.video), .pixel_strobe(link.pixel_strobe), .scan_done_flag(link.scan_done_flag));
  always #5 clk_in = ~clk_in;
  // ==================================================
  // shared tasks
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    if (failures == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic give_up(input int spent, input int limit);
    if (spent >= limit) begin
      failures++;
      close_out();
    end
  endtask
  task automatic tick();
    @(posedge clk_in);
    #1;
  endtask
  // ==================================================
  // pixel source and wire monitor
  always @(posedge clk_in) begin
    #1;
    pixel_data_in = pixel_index ^ PAT;
  end
  always @(posedge clk_in) begin
    prev_strobe <= link.pixel_strobe;
    if (rst_in || link.line_begin_pulse)
      wk <= 12'h000;
    else if (link.pixel_strobe && !prev_strobe) begin
      wk <= wk + 12'h001;
      if (wk >= `LAST_DARK_STROBE)
        check({4'h0, link.video}, {4'h0, (wk - `LAST_DARK_STROBE) ^ PAT});
    end
  end
  // ==================================================
  // one line; a second start mid-line must be ignored
  task automatic run_line(input logic [15:0] high, input logic [15:0] exp_integ);
    int n;
    int i;
    logic seen_integ;
    n = 0;
    seen_integ = 1'b0;
    start_in = 1'b1;
    high_periods_in = high;
    for (i = 0; i < 100 && busy !== 1'b1; i++)
      tick();
    give_up(i, 100);
    start_in = 1'b0;
    for (i = 0; i < 60000 && line_done !== 1'b1; i++) begin
      tick();
      if (integ_valid === 1'b1) begin
        seen_integ = 1'b1;
        check(integ, exp_integ);
        check({15'h0, dev_busy}, 16'h0001);
      end
      if (sample_valid === 1'b1) begin
        check({4'h0, sample_index}, 16'(n));
        check({4'h0, sample}, {4'h0, 12'(n) ^ PAT});
        n++;
      end
      start_in = (n > 100 && n < 200);
    end
    give_up(i, 60000);
    check({15'h0, dev_busy}, 16'h0001);
    check(16'(n), {4'h0, `PIXELS_PER_LINE});
    check({15'h0, seen_integ}, 16'h0001);
    tick();
    tick();
    check({15'h0, count_ok}, 16'h0001);
    check({15'h0, rate_fault}, 16'h0000);
    for (i = 0; i < 3000 && busy !== 1'b0; i++)
      tick();
    check({15'h0, busy}, 16'h0000);
    give_up(i, 3000);
    for (i = 0; i < 100 && dev_busy !== 1'b0; i++)
      tick();
    check({15'h0, dev_busy}, 16'h0000);
    give_up(i, 100);
  endtask
  // ==================================================
  // scenarios
  task automatic test_short_high();
    run_line(16'h0003, `BEGIN_HIGH_MIN + `INTEG_EXTRA_CYC);
  endtask
  task automatic test_longer_high();
    run_line(16'h0009, 16'h0009 + `INTEG_EXTRA_CYC);
  endtask
  initial begin
    repeat (5) @(posedge clk_in);
    #1;
    rst_in = 1'b0;
    test_short_high();
    test_longer_high();
    close_out();
  end
endmodule // linear_sensor_readout_timing_tb
`default_nettype wire
